// ### design/dmc_buf2.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================
// two-entry buffer between read and write side
module dmc_buf2 (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire dmc_pkg::dmc_word_t in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output dmc_pkg::dmc_word_t out_data_out
);
    import dmc_pkg::*;

    dmc_word_t mem [0:1];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    assign in_ready_out = (count_reg != 2'h2);
    assign out_valid_out = (count_reg != 2'h0);
    assign out_data_out = mem[rd_ptr_reg];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else if (flush_in) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : dmc_buf2

`default_nettype wire

// ### design/dmc_channel.sv
// Operation
// - Source select 00 increments the source address per transfer, 10 holds it, 11 wraps, 01 is reserved.
// - In wrap mode a byte count of zero reloads current source address and count and restarts.
// - In wrap mode reload-and-transfer repeats until software clears the channel enable.
// - Clearing the enable lets the transfer in flight finish and discards buffered data.
// - Direction 00 is SRAM to SRAM, 01 is APB to SRAM and 10 is SRAM to APB.
// - Writing 0 to the soft reset bit does nothing.
// - Writing 1 to the soft reset bit resets the state machine and the address and count pointers.
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dmc_regs.svh"

module dmc_channel (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire dmc_pkg::dmc_word_t wb_dat_in,
    output dmc_pkg::dmc_word_t wb_dat_out,
    output logic wb_ack_out,
    // read port
    output logic rd_req_out,
    output dmc_pkg::dmc_word_t rd_addr_out,
    output logic rd_periph_out,
    input wire logic rd_ack_in,
    input wire dmc_pkg::dmc_word_t rd_data_in,
    // write port
    output logic wr_req_out,
    output dmc_pkg::dmc_word_t wr_addr_out,
    output dmc_pkg::dmc_word_t wr_data_out,
    output logic wr_periph_out,
    input wire logic wr_ack_in
);
    import dmc_pkg::*;

    // =====================================
    // reset release
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // =====================================
    // helpers
    function automatic dmc_word_t merge_lanes(input dmc_word_t old_val, input dmc_word_t new_val,
                                             input logic [3:0] sel);
        dmc_word_t res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction : merge_lanes

    function automatic dmc_word_t step_addr(input dmc_word_t addr, input logic hold);
        return hold ? addr : addr + `DMC_ADDR_STEP;
    endfunction : step_addr

    // =====================================
    // registers
    logic enable_reg;
    dmc_dir_e dir_reg;
    dmc_src_sel_e src_sel_reg;
    dmc_word_t prog_src_reg;
    dmc_word_t prog_dst_reg;
    logic [15:0] prog_cnt_reg;
    dmc_word_t cur_src_reg;
    dmc_word_t cur_dst_reg;
    logic [15:0] cur_cnt_reg;
    dmc_state_e state_reg;
    logic done_reg;
    logic enable_d_reg;

    wire bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire bus_wr = bus_req && wb_we_in;
    wire wr_ctrl = bus_wr && (wb_adr_in == `DMC_OFS_CTRL);
    dmc_word_t ctrl_new;
    assign ctrl_new = merge_lanes(`DMC_CTRL_RESET, wb_dat_in, wb_sel_in);
    dmc_word_t cnt_merged;
    assign cnt_merged = merge_lanes({16'h0, prog_cnt_reg}, wb_dat_in, wb_sel_in);
    wire soft_rst = wr_ctrl && wb_sel_in[0] && ctrl_new[`DMC_CTRL_SOFTRST_BIT];
    wire start = enable_reg && !enable_d_reg && (state_reg == DMC_ST_IDLE);

    dmc_word_t ctrl_rd;
    assign ctrl_rd = {26'h0, src_sel_reg, dir_reg, 1'b0, enable_reg};
    dmc_word_t status_rd;
    assign status_rd = {29'h0, state_reg == DMC_ST_STOP, done_reg, state_reg != DMC_ST_IDLE};

    dmc_word_t rd_mux;
    assign rd_mux = (wb_adr_in == `DMC_OFS_CTRL) ? ctrl_rd :
                    (wb_adr_in == `DMC_OFS_SRC) ? prog_src_reg :
                    (wb_adr_in == `DMC_OFS_DST) ? prog_dst_reg :
                    (wb_adr_in == `DMC_OFS_CNT) ? {16'h0, prog_cnt_reg} :
                    (wb_adr_in == `DMC_OFS_CUR_SRC) ? cur_src_reg :
                    (wb_adr_in == `DMC_OFS_CUR_DST) ? cur_dst_reg :
                    (wb_adr_in == `DMC_OFS_CUR_CNT) ? {16'h0, cur_cnt_reg} :
                    (wb_adr_in == `DMC_OFS_STATUS) ? status_rd : 32'h0000_0000;

    // =====================================
    // bus slave: ack one cycle after request
    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= bus_req;
            wb_dat_out <= (bus_req && !wb_we_in) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            enable_reg <= 1'b0;
            dir_reg <= DMC_DIR_MEM_MEM;
            src_sel_reg <= DMC_SRC_INC;
            prog_src_reg <= `DMC_ADDR_RESET;
            prog_dst_reg <= `DMC_ADDR_RESET;
            prog_cnt_reg <= `DMC_CNT_RESET;
            enable_d_reg <= 1'b0;
        end else begin
            enable_d_reg <= enable_reg;
            if (wr_ctrl && wb_sel_in[0]) begin
                enable_reg <= ctrl_new[`DMC_CTRL_EN_BIT];
                dir_reg <= dmc_dir_e'(ctrl_new[`DMC_CTRL_DIR_LSB +: 2]);
                src_sel_reg <= dmc_src_sel_e'(ctrl_new[`DMC_CTRL_SRCSEL_LSB +: 2]);
            end
            if (bus_wr && wb_adr_in == `DMC_OFS_SRC) begin
                prog_src_reg <= merge_lanes(prog_src_reg, wb_dat_in, wb_sel_in);
            end
            if (bus_wr && wb_adr_in == `DMC_OFS_DST) begin
                prog_dst_reg <= merge_lanes(prog_dst_reg, wb_dat_in, wb_sel_in);
            end
            if (bus_wr && wb_adr_in == `DMC_OFS_CNT) begin
                prog_cnt_reg <= cnt_merged[15:0];
            end
        end
    end

    // =====================================
    // data path
    logic buf_in_ready;
    logic buf_out_valid;
    dmc_word_t buf_out_data;
    wire running = (state_reg == DMC_ST_RUN) && enable_reg;
    wire rd_done = rd_req_out && rd_ack_in;
    wire wr_done = wr_req_out && wr_ack_in;
    wire buf_push = rd_done && running;
    wire buf_pop = buf_out_valid && !wr_req_out && running;
    wire flush = soft_rst || !running;
    wire src_hold = (src_sel_reg == DMC_SRC_FIXED) || (src_sel_reg == DMC_SRC_RSVD);
    wire dst_hold = (dir_reg == DMC_DIR_MEM_PER);
    wire cnt_zero = (cur_cnt_reg == 16'h0000);
    wire issue_rd = running && !rd_req_out && !cnt_zero && buf_in_ready;
    wire wrap_now = running && cnt_zero && !rd_req_out && (src_sel_reg == DMC_SRC_WRAP);
    wire finish = running && cnt_zero && !rd_req_out && !wrap_now && !buf_out_valid
                  && !wr_req_out;
    wire [15:0] cnt_dec = (cur_cnt_reg > `DMC_XFER_BYTES) ? cur_cnt_reg - `DMC_XFER_BYTES
                                                          : 16'h0000;

    dmc_buf2 u_buf (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n_reg),
        .flush_in(flush),
        .in_valid_in(buf_push),
        .in_ready_out(buf_in_ready),
        .in_data_in(rd_data_in),
        .out_valid_out(buf_out_valid),
        .out_ready_in(buf_pop),
        .out_data_out(buf_out_data)
    );

    // =====================================
    // channel state machine
    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= DMC_ST_IDLE;
            done_reg <= 1'b0;
        end else if (soft_rst) begin
            state_reg <= DMC_ST_IDLE;
            done_reg <= 1'b0;
        end else begin
            case (state_reg)
                DMC_ST_IDLE: begin
                    if (start) begin
                        state_reg <= DMC_ST_RUN;
                        done_reg <= 1'b0;
                    end
                end
                DMC_ST_RUN: begin
                    if (!enable_reg) begin
                        state_reg <= DMC_ST_STOP;
                    end else if (finish) begin
                        state_reg <= DMC_ST_IDLE;
                        done_reg <= 1'b1;
                    end
                end
                DMC_ST_STOP: begin
                    if (!rd_req_out && !wr_req_out) begin
                        state_reg <= DMC_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= DMC_ST_IDLE;
                end
            endcase
        end
    end

    // =====================================
    // pointers and read side
    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cur_src_reg <= `DMC_ADDR_RESET;
            cur_cnt_reg <= `DMC_CNT_RESET;
            rd_req_out <= 1'b0;
            rd_addr_out <= `DMC_ADDR_RESET;
            rd_periph_out <= 1'b0;
        end else if (soft_rst) begin
            cur_src_reg <= `DMC_ADDR_RESET;
            cur_cnt_reg <= `DMC_CNT_RESET;
            rd_req_out <= 1'b0;
        end else if (start || wrap_now) begin
            cur_src_reg <= prog_src_reg;
            cur_cnt_reg <= prog_cnt_reg;
        end else if (issue_rd) begin
            rd_req_out <= 1'b1;
            rd_addr_out <= cur_src_reg;
            rd_periph_out <= (dir_reg == DMC_DIR_PER_MEM);
        end else if (rd_done) begin
            rd_req_out <= 1'b0;
            cur_src_reg <= step_addr(cur_src_reg, src_hold);
            cur_cnt_reg <= cnt_dec;
        end
    end

    // =====================================
    // write side
    always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cur_dst_reg <= `DMC_ADDR_RESET;
            wr_req_out <= 1'b0;
            wr_addr_out <= `DMC_ADDR_RESET;
            wr_data_out <= 32'h0000_0000;
            wr_periph_out <= 1'b0;
        end else if (soft_rst) begin
            cur_dst_reg <= `DMC_ADDR_RESET;
            wr_req_out <= 1'b0;
        end else begin
            // a pop or a completion in the reload cycle must not be lost
            if (buf_pop) begin
                wr_req_out <= 1'b1;
                wr_addr_out <= cur_dst_reg;
                wr_data_out <= buf_out_data;
                wr_periph_out <= dst_hold;
            end else if (wr_done) begin
                wr_req_out <= 1'b0;
            end
            if (start || wrap_now) begin
                cur_dst_reg <= prog_dst_reg;
            end else if (wr_done) begin
                cur_dst_reg <= step_addr(cur_dst_reg, dst_hold);
            end
        end
    end
endmodule : dmc_channel

`default_nettype wire

// ### shared/dmc_pkg.sv
package dmc_pkg;
    typedef enum logic [1:0] {
        DMC_SRC_INC = 2'h0,
        DMC_SRC_RSVD = 2'h1,
        DMC_SRC_FIXED = 2'h2,
        DMC_SRC_WRAP = 2'h3
    } dmc_src_sel_e;

    typedef enum logic [1:0] {
        DMC_DIR_MEM_MEM = 2'h0,
        DMC_DIR_PER_MEM = 2'h1,
        DMC_DIR_MEM_PER = 2'h2,
        DMC_DIR_RSVD = 2'h3
    } dmc_dir_e;

    typedef enum logic [1:0] {
        DMC_ST_IDLE,
        DMC_ST_RUN,
        DMC_ST_STOP
    } dmc_state_e;

    typedef logic [31:0] dmc_word_t;
endpackage : dmc_pkg

// ### shared/dmc_regs.svh
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH

// =====================================
// register offsets (byte addresses)
`define DMC_OFS_CTRL 8'h00
`define DMC_OFS_SRC 8'h04
`define DMC_OFS_DST 8'h08
`define DMC_OFS_CNT 8'h0c
`define DMC_OFS_CUR_SRC 8'h10
`define DMC_OFS_CUR_DST 8'h14
`define DMC_OFS_CUR_CNT 8'h18
`define DMC_OFS_STATUS 8'h1c

// =====================================
// control field positions
`define DMC_CTRL_EN_BIT 0
`define DMC_CTRL_SOFTRST_BIT 1
`define DMC_CTRL_DIR_LSB 2
`define DMC_CTRL_SRCSEL_LSB 4

// =====================================
// status field positions
`define DMC_STAT_BUSY_BIT 0
`define DMC_STAT_DONE_BIT 1
`define DMC_STAT_STOP_BIT 2

// =====================================
// reset values and sizes
`define DMC_CTRL_RESET 32'h0000_0000
`define DMC_ADDR_RESET 32'h0000_0000
`define DMC_CNT_RESET 16'h0000
`define DMC_XFER_BYTES 16'h0004
`define DMC_ADDR_STEP 32'h0000_0004

`endif

// ### sim/dmc_channel_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// port checker
module dmc_channel_monitor (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire dmc_pkg::dmc_word_t wb_dat_in,
    input wire dmc_pkg::dmc_word_t wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic rd_req_out,
    input wire dmc_pkg::dmc_word_t rd_addr_out,
    input wire logic rd_periph_out,
    input wire logic rd_ack_in,
    input wire logic wr_req_out,
    input wire dmc_pkg::dmc_word_t wr_data_out,
    input wire logic wr_periph_out,
    input wire logic wr_ack_in
);
    import dmc_pkg::*;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    logic req_take, ctl_wr, soft_take, rd_done, seen_reg;
    logic [1:0] dir_reg, ssel_reg;
    dmc_word_t last_reg;
    assign req_take = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign ctl_wr = req_take && wb_we_in && wb_adr_in == 8'h00 && wb_sel_in[0];
    assign soft_take = ctl_wr && wb_dat_in[1];
    assign rd_done = rd_req_out && rd_ack_in;
    // shadow of mode fields and last read address
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dir_reg <= 2'h0;
            ssel_reg <= 2'h0;
            seen_reg <= 1'b0;
            last_reg <= 32'h0;
        end else begin
            if (ctl_wr) begin
                dir_reg <= wb_dat_in[3:2];
                ssel_reg <= wb_dat_in[5:4];
            end
            seen_reg <= !ctl_wr && (seen_reg || rd_done);
            if (rd_done) begin
                last_reg <= rd_addr_out;
            end
        end
    end
    chk_ack_next: assert property (req_take |=> wb_ack_out)
        else $error("bus ack missing");
    chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("bus ack too long");
    chk_rd_hold: assert property (rd_req_out && !rd_ack_in && !soft_take
                                  |=> rd_req_out && $stable(rd_addr_out))
        else $error("read request not held");
    chk_wr_hold: assert property (wr_req_out && !wr_ack_in && !soft_take
                                  |=> wr_req_out && $stable(wr_data_out))
        else $error("write request not held");
    chk_rd_release: assert property (rd_done |=> !rd_req_out)
        else $error("read request kept after ack");
    chk_softrst_reads_zero: assert property (req_take && !wb_we_in && wb_adr_in == 8'h00 |=> !wb_dat_out[1])
        else $error("soft reset bit read as one");
    chk_src_inc: assert property ($rose(rd_req_out) && seen_reg && ssel_reg == 2'h0 |-> rd_addr_out == last_reg + 32'h4)
        else $error("source address did not step");
    chk_src_fixed: assert property ($rose(rd_req_out) && seen_reg && (ssel_reg == 2'h2 || ssel_reg == 2'h1) |-> rd_addr_out == last_reg)
        else $error("source address moved");
    chk_dir_periph: assert property ((!rd_req_out || rd_periph_out == (dir_reg == 2'h1)) && (!wr_req_out || wr_periph_out == (dir_reg == 2'h2)))
        else $error("wrong target for direction");
    chk_softrst_stops: assert property (soft_take |-> ##1 (!rd_req_out && !wr_req_out) [*2])
        else $error("requests survive soft reset");
    cov_wrap_read: cover property (ssel_reg == 2'h3 && rd_done);
    cov_soft_reset: cover property (soft_take);
    cov_wr_stall: cover property ((wr_req_out && !wr_ack_in) [*3]);
endmodule : dmc_channel_monitor

bind dmc_channel dmc_channel_monitor u_dmc_channel_monitor (.clk_sys_in, .resetn_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .rd_req_out, .rd_addr_out, .rd_periph_out, .rd_ack_in, .wr_req_out, .wr_data_out,
    .wr_periph_out, .wr_ack_in);
`default_nettype wire

// ### sim/dmc_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// memory side responder, latency per port
module dmc_mem_model #(parameter logic [31:0] RD_XOR = 32'h0) (
    input wire logic clk_sys_in,
    input wire logic rd_req_in,
    input wire logic [31:0] rd_addr_in,
    output logic rd_ack_out,
    output logic [31:0] rd_data_out,
    input wire logic wr_req_in,
    input wire logic [31:0] wr_addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_periph_in,
    output logic wr_ack_out,
    input wire logic [3:0] rd_dly_in,
    input wire logic [3:0] wr_dly_in
);
    logic [31:0] wa_q[$];
    logic [31:0] wd_q[$];
    logic [31:0] wp_q[$];
    logic [3:0] rd_cnt = 4'h0;
    logic [3:0] wr_cnt = 4'h0;
    logic rd_go, wr_go;
    initial begin
        rd_ack_out = 1'b0;
        wr_ack_out = 1'b0;
        rd_data_out = 32'h0;
    end
    assign rd_go = rd_req_in && !rd_ack_out;
    assign wr_go = wr_req_in && !wr_ack_out;
    always @(posedge clk_sys_in) begin
        rd_ack_out <= 1'b0;
        wr_ack_out <= 1'b0;
        // idle data changes every cycle
        rd_data_out <= ~rd_data_out;
        if (wr_req_in && wr_ack_out) begin
            wa_q.push_back(wr_addr_in);
            wd_q.push_back(wr_data_in);
            wp_q.push_back({31'h0, wr_periph_in});
        end
        if (rd_go && rd_cnt == rd_dly_in) begin
            rd_ack_out <= 1'b1;
            rd_data_out <= rd_addr_in ^ RD_XOR;
        end
        if (wr_go && wr_cnt == wr_dly_in) begin
            wr_ack_out <= 1'b1;
        end
        rd_cnt <= (rd_go && rd_cnt != rd_dly_in) ? rd_cnt + 4'h1 : 4'h0;
        wr_cnt <= (wr_go && wr_cnt != wr_dly_in) ? wr_cnt + 4'h1 : 4'h0;
    end
endmodule : dmc_mem_model
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "dmc_regs.svh"
module tb;
    import dmc_pkg::*;
    localparam dmc_word_t PAT = 32'ha5a5_0000;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h0;
    dmc_word_t wb_dat_in = 32'h0;
    dmc_word_t wb_dat_out, rd_addr_out, rd_data_in, wr_addr_out, wr_data_out, rd_q;
    logic wb_ack_out, rd_req_out, rd_periph_out, rd_ack_in, wr_req_out, wr_periph_out, wr_ack_in;
    logic [3:0] rd_dly = 4'h0;
    logic [3:0] wr_dly = 4'h0;
    dmc_word_t modes[4] = '{32'h01, 32'h25, 32'h19, 32'h0d};
    int err_count = 0;
    int n_tests = 0;
    int base, cnt, n;
    dmc_channel u_dmc_channel (.clk_sys_in, .resetn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
        .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .rd_req_out, .rd_addr_out,
        .rd_periph_out, .rd_ack_in, .rd_data_in, .wr_req_out, .wr_addr_out, .wr_data_out,
        .wr_periph_out, .wr_ack_in);
    dmc_mem_model #(.RD_XOR(PAT)) u_dmc_mem_model (.clk_sys_in, .rd_req_in(rd_req_out),
        .rd_addr_in(rd_addr_out), .rd_ack_out(rd_ack_in), .rd_data_out(rd_data_in),
        .wr_req_in(wr_req_out), .wr_addr_in(wr_addr_out), .wr_data_in(wr_data_out),
        .wr_periph_in(wr_periph_out), .wr_ack_out(wr_ack_in), .rd_dly_in(rd_dly),
        .wr_dly_in(wr_dly));
    // ====
    // helpers
    initial forever #10 clk_sys_in = ~clk_sys_in;
    function automatic int logged();
        return u_dmc_mem_model.wa_q.size();
    endfunction : logged
    task automatic check(input dmc_word_t seen, input dmc_word_t exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("errors=%0d checks=%0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // classic cycle, released only after ack is sampled
    task automatic wbx(input logic we, input logic [7:0] adr, input dmc_word_t d);
        @(posedge clk_sys_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= adr;
        wb_dat_in <= d;
        wb_sel_in <= 4'hf;
        do begin
            @(posedge clk_sys_in);
        end while (wb_ack_out !== 1'b1);
        rd_q = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask : wbx
    task automatic wait_stat(input dmc_word_t mask, input dmc_word_t val);
        n = 0;
        do begin
            wbx(1'b0, `DMC_OFS_STATUS, 32'h0);
            n++;
        end while ((rd_q & mask) !== val && n < 400);
        if ((rd_q & mask) !== val) begin
            err_count++;
        end
    endtask : wait_stat
    task automatic wait_log(input int k);
        n = 0;
        while (logged() - base < k && n < 3000) begin
            @(posedge clk_sys_in);
            n++;
        end
        if (logged() - base < k) begin
            err_count++;
        end
    endtask : wait_log
    task automatic start(input dmc_word_t ctrl, input dmc_word_t bytes);
        base = logged();
        wbx(1'b1, `DMC_OFS_CTRL, 32'h0);
        wbx(1'b1, `DMC_OFS_CNT, bytes);
        wbx(1'b1, `DMC_OFS_CTRL, ctrl);
    endtask : start
    // ====
    // scenarios
    initial begin
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        wbx(1'b0, `DMC_OFS_CTRL, 32'h0);
        check(rd_q, `DMC_CTRL_RESET);
        wbx(1'b0, 8'h20, 32'h0);
        check(rd_q, 32'h0);
        wbx(1'b1, `DMC_OFS_SRC, 32'h100);
        wbx(1'b1, `DMC_OFS_DST, 32'h200);
        foreach (modes[i]) begin
            rd_dly <= 4'(i);
            wr_dly <= 4'(2 * i);
            start(modes[i], 32'd12);
            wait_stat(32'h2, 32'h2);
            check(32'(logged() - base), 32'd3);
            for (int j = 0; j < 3; j++) begin
                check(u_dmc_mem_model.wa_q[base + j], 32'h200 + ((modes[i][3:2] == 2'h2) ? 0 : 4 * j));
                check(u_dmc_mem_model.wd_q[base + j], (32'h100 + ((modes[i][5:4] == 2'h0) ? 4 * j : 0)) ^ PAT);
                check(u_dmc_mem_model.wp_q[base + j], 32'(modes[i][3:2] == 2'h2));
            end
        end
        rd_dly <= 4'h0;
        wr_dly <= 4'h5;
        start(32'h31, 32'd8);
        wait_log(6);
        wbx(1'b1, `DMC_OFS_CTRL, 32'h30);
        wait_stat(32'h5, 32'h0);
        cnt = logged();
        check(32'(cnt - base >= 6), 32'h1);
        for (int j = 0; j < 6; j++) begin
            check(u_dmc_mem_model.wd_q[base + j], (32'h100 + 4 * (j % 2)) ^ PAT);
        end
        repeat (30) @(posedge clk_sys_in);
        check(32'(logged()), 32'(cnt));
        start(32'h01, 32'd64);
        wait_log(2);
        wbx(1'b1, `DMC_OFS_CTRL, 32'h03);
        wbx(1'b0, `DMC_OFS_CTRL, 32'h0);
        check(rd_q, 32'h01);
        wbx(1'b0, `DMC_OFS_CUR_SRC, 32'h0);
        check(rd_q, 32'h0);
        wbx(1'b0, `DMC_OFS_CUR_CNT, 32'h0);
        check(rd_q, 32'h0);
        wbx(1'b0, `DMC_OFS_CUR_DST, 32'h0);
        check(rd_q, 32'h0);
        cnt = logged();
        wbx(1'b1, `DMC_OFS_CTRL, 32'h01);
        repeat (30) @(posedge clk_sys_in);
        check(32'(logged()), 32'(cnt));
        wbx(1'b0, `DMC_OFS_STATUS, 32'h0);
        check(rd_q & 32'h1, 32'h0);
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge clk_sys_in);
        err_count++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
